/* design/fls_sequencer.sv */
// LED mode sequencer: APB registers, mode entry, current ramps, fault checks, flash timer.
// Assumes pins come from outside the clock domain and an analog regulator follows O_LED_MA.
// Overview of operation
// [R1] In shutdown only torch starts, via the debounced torch pin with its allow bit.
// [R2] Standby torch: pin with allow and on bit, or on bit with allow clear.
// [R3] Torch pin is debounced both on rise and on fall.
// [R4] Torch ramps 30 to 100 mA by 10 mA per step, holds, then ramps to final.
// [R5] Torch checks open/short at full scale; fault disables and returns to idle.
// [R6] Assist starts from standby with function 10, by strobe or on bit.
// [R7] Strobe input for assist is used without debouncing.
// [R8] Assist ramps like torch, checks at full scale, then ramps to final.
// [R9] Flash with function 11 starts by strobe with chip enable, or by on bit.
// [R10] Flash waits for boost soft-start before ramping in 50 mA sections.
// [R11] Flash checks open/short at 100 mA, then continues to final.
// [R12] Duration style bit applies to strobe flash; register flash is always one-shot.
// [R13] Indicator with function 01 and select set, by strobe or on bit.
// [R14] Enables and disables ramp one step per ramp tick in torch and assist, one per two ticks in flash; faults and maximum-duration expiry cut at once.
// [R15] Flash ramp starts at 50 mA and steps 50 mA every two step periods.
// [R16] Ramp on enable and level changes; no ramp on a fault.
// [R17] Safety timer runs in every flash, 1.024 ms units, ends flash at expiry.
// [R18] Target is torch level in torch and assist, flash level in flash.
// [R19] Maximum-duration flash follows strobe; expiry first latches a fault.
// [R20] One-shot flash ends at expiry and latches no fault.
// [R21] Only one mode at a time; new requests wait until idle.
`timescale 1ns/1ps
module fls_sequencer #(
    parameter int TICK_CYC = fls_pkg::TIMER_TICK_CYC
) (
    input  wire logic        I_MCLK,
    input  wire logic        I_SYS_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic        I_TORCH_EN,
    input  wire logic        I_STROBE,
    input  wire logic        I_CHIP_EN,
    input  wire logic        I_MAIN_LED_OUTPUT_FAULT,
    input  wire logic        I_IND_FAULT,
    input  wire logic        I_BOOST_READY,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic [10:0]      O_LED_MA,
    output logic             O_MAIN_LED_OUTPUT_ON,
    output logic             O_BOOST_ON,
    output logic             O_IND_ON
);
    // Pin synchronisers, two flops each; only the second stage is read.
    logic [4:0] meta;
    logic [4:0] pin;
    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_sync
            always_ff @(posedge I_MCLK)
            begin
                meta[g] <= I_SYS_RST ? 1'b0 : (g == 0 ? I_TORCH_EN : g == 1 ? I_STROBE :
                           g == 2 ? I_CHIP_EN : g == 3 ? I_MAIN_LED_OUTPUT_FAULT : I_IND_FAULT);
                pin[g]  <= I_SYS_RST ? 1'b0 : meta[g];
            end
        end
    endgenerate
    logic boost_meta;
    logic boost_ok;
    wire torch_pin = pin[0];
    wire strobe    = pin[1];
    wire chip_en   = pin[2];
    wire main_led_output_flt  = pin[3];
    wire ind_flt   = pin[4];

    // Registers and state.
    fls_pkg::fls_ctrl_s  ctrl;
    logic [7:0]          level;
    logic [7:0]          tmr_set;
    logic                main_led_output_fault;
    logic                ind_fault;
    logic                tmr_fault;
    fls_pkg::fls_state_e state;
    fls_pkg::fls_state_e next_state;
    fls_pkg::fls_mode_e  mode;
    fls_pkg::fls_mode_e  next_mode;
    logic [10:0]         cur;
    logic [10:0]         next_cur;
    logic                src_pin;
    logic                next_src;
    logic                db_level;
    logic [11:0]         db_cnt;
    logic [11:0]         hold_cnt;
    logic [9:0]          rdiv;
    logic                half;
    logic [15:0]         tick_cnt;
    logic [7:0]          units;
    logic                strobe_d;
    logic                main_led_output_ev;
    logic                ind_ev;
    logic                tmr_ev;
    logic                clr_on;

    // APB decode; all answers take one wait-free access phase.
    wire setup    = I_PSEL & ~I_PENABLE;
    wire done     = I_PSEL & I_PENABLE & O_PREADY;
    wire hit_ctrl = I_PADDR == fls_pkg::ADDR_CTRL;
    wire hit_lvl  = I_PADDR == fls_pkg::ADDR_LEVEL;
    wire hit_tmr  = I_PADDR == fls_pkg::ADDR_TIMER;
    wire hit_stat = I_PADDR == fls_pkg::ADDR_STATUS;
    wire mapped   = hit_ctrl | hit_lvl | hit_tmr | hit_stat;
    wire wr       = done & I_PWRITE;
    wire rd_stat  = done & ~I_PWRITE & hit_stat;
    wire [31:0] stat_word = {5'h00, cur, 9'h000, 3'(mode), 1'b0, tmr_fault, ind_fault, main_led_output_fault};
    wire [31:0] rd_word   = hit_ctrl ? {25'h0000000, ctrl} : hit_lvl ? {24'h000000, level} :
                            hit_tmr ? {24'h000000, tmr_set} : hit_stat ? stat_word : 32'h00000000;

    always_ff @(posedge I_MCLK)
    begin
        O_PREADY  <= ~I_SYS_RST & setup;
        O_PSLVERR <= ~I_SYS_RST & setup & ~mapped;
        if (I_SYS_RST) O_PRDATA <= 32'h00000000;
        else if (setup) O_PRDATA <= I_PWRITE ? 32'h00000000 : rd_word;
    end

    // Register writes; a software write of the control word wins over the hardware clear.
    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            ctrl    <= fls_pkg::CTRL_RST;
            level   <= fls_pkg::LEVEL_RST;
            tmr_set <= fls_pkg::TIMER_RST;
        end
        else
        begin
            if (wr && hit_ctrl) ctrl <= I_PWDATA[6:0];
            else if (clr_on) ctrl.led_output_on_bit <= 1'b0;
            if (wr && hit_lvl) level <= I_PWDATA[7:0];
            if (wr && hit_tmr) tmr_set <= I_PWDATA[7:0];
        end
    end

    // Sticky faults clear on read, but only bits the read returned; a new event wins.
    wire [2:0] seen = rd_stat ? O_PRDATA[2:0] : 3'h0;
    always_ff @(posedge I_MCLK)
    begin
        main_led_output_fault <= ~I_SYS_RST & (main_led_output_ev | (main_led_output_fault & ~seen[0]));
        ind_fault  <= ~I_SYS_RST & (ind_ev  | (ind_fault  & ~seen[1]));
        tmr_fault  <= ~I_SYS_RST & (tmr_ev  | (tmr_fault  & ~seen[2]));
    end

    // [R3] torch pin debounce
    wire db_flip = (torch_pin != db_level) && db_cnt == 12'(fls_pkg::DEBOUNCE_CYC - 1);
    always_ff @(posedge I_MCLK)
    begin
        db_cnt   <= (I_SYS_RST || torch_pin == db_level || db_flip) ? 12'h000 : db_cnt + 12'h001;
        db_level <= I_SYS_RST ? 1'b0 : (db_flip ? torch_pin : db_level);
    end

    // Strobe edge and boost ready; the strobe is used raw, with no filter.
    // [R7] strobe without debounce
    always_ff @(posedge I_MCLK)
    begin
        strobe_d   <= ~I_SYS_RST & strobe;
        boost_meta <= ~I_SYS_RST & I_BOOST_READY;
        boost_ok   <= ~I_SYS_RST & boost_meta;
    end

    // [R14] ramp step ticks
    wire rtick = rdiv == 10'(fls_pkg::RAMP_STEP_CYC - 1);
    // [R15] flash steps every second tick
    wire step  = rtick & (mode != fls_pkg::MODE_FLASH | half);
    wire busy  = state != fls_pkg::ST_IDLE;
    // The divider restarts when the ramp starts, so a long soft-start cannot shorten the first step.
    wire ramp_held = !busy || state == fls_pkg::ST_SOFTSTART;
    always_ff @(posedge I_MCLK)
    begin
        rdiv     <= (I_SYS_RST || ramp_held || rtick) ? 10'h000 : rdiv + 10'h001;
        half     <= (I_SYS_RST || ramp_held) ? 1'b0 : half ^ rtick;
        hold_cnt <= (I_SYS_RST || state != fls_pkg::ST_HOLD) ? 12'h000 : hold_cnt + 12'h001;
    end

    // [R17] safety timer in 1.024 ms units
    wire tick_end = tick_cnt == 16'(TICK_CYC - 1);
    wire flash_on = mode == fls_pkg::MODE_FLASH && busy;
    wire expire   = flash_on && tick_end && units == tmr_set;
    always_ff @(posedge I_MCLK)
    begin
        tick_cnt <= (I_SYS_RST || !flash_on || tick_end) ? 16'h0000 : tick_cnt + 16'h0001;
        units    <= (I_SYS_RST || !flash_on) ? 8'h00 : units + {7'h00, tick_end};
    end

    // Entry requests.
    wire       on      = ctrl.led_output_on_bit;
    wire       allow   = ctrl.strobe_input_allow;
    wire [1:0] fn      = ctrl.led_output_function_sel;
    // [R1] shutdown torch by pin only
    wire torch_pin_go  = fn == fls_pkg::FN_TORCH && db_level && ctrl.torch_allow && (!chip_en || on);
    // [R2] standby torch entry
    wire torch_go      = torch_pin_go || (chip_en && on && fn == fls_pkg::FN_TORCH && !ctrl.torch_allow);
    // [R6] assist entry from standby
    wire assist_go     = chip_en && on && fn == fls_pkg::FN_ASSIST && (!allow || strobe);
    // [R9] flash entry on strobe edge
    wire flash_go      = chip_en && on && fn == fls_pkg::FN_FLASH && (!allow || (strobe && !strobe_d));
    // [R13] indicator entry
    wire ind_go        = chip_en && on && fn == fls_pkg::FN_IND && ctrl.indicator_select && (!allow || strobe);
    // [R12] level style only for strobe flash
    wire max_style     = src_pin && ctrl.duration_style;
    wire is_flash      = mode == fls_pkg::MODE_FLASH;
    wire [10:0] lsb    = is_flash ? fls_pkg::FLASH_LSB_MA : fls_pkg::TORCH_LSB_MA;
    wire [10:0] start  = is_flash ? fls_pkg::FLASH_START_MA : fls_pkg::TORCH_START_MA;
    // [R18] target by mode
    wire [10:0] target = is_flash ? fls_pkg::FLASH_BASE_MA + 11'(level[7:4]) * fls_pkg::FULL_SCALE_MA
                                  : fls_pkg::TORCH_START_MA + 11'(level[2:0]) * fls_pkg::TORCH_LSB_MA;
    // [R19] strobe level ends maximum-duration flash
    wire stop = mode == fls_pkg::MODE_TORCH ? (src_pin ? !db_level :
                    !(on && chip_en && fn == fls_pkg::FN_TORCH && !ctrl.torch_allow)) :
                !chip_en || !on || (src_pin && !strobe && (!is_flash || max_style));
    wire mon  = state == fls_pkg::ST_CHECK || state == fls_pkg::ST_HOLD || state == fls_pkg::ST_SETTLE;

    // Sequencer next-state logic.
    always_comb
    begin
        next_state = state;
        next_mode  = mode;
        next_cur   = cur;
        next_src   = src_pin;
        main_led_output_ev    = 1'b0;
        ind_ev     = 1'b0;
        tmr_ev     = 1'b0;
        clr_on     = 1'b0;
        unique case (state)
            // [R21] new requests only from idle
            fls_pkg::ST_IDLE:
                if (!main_led_output_fault && torch_go)
                begin
                    next_mode  = fls_pkg::MODE_TORCH;
                    next_state = fls_pkg::ST_RAMP_UP;
                    next_cur   = fls_pkg::TORCH_START_MA;
                    next_src   = torch_pin_go;
                end
                else if (!main_led_output_fault && assist_go)
                begin
                    next_mode  = fls_pkg::MODE_ASSIST;
                    next_state = fls_pkg::ST_RAMP_UP;
                    next_cur   = fls_pkg::TORCH_START_MA;
                    next_src   = allow;
                end
                else if (!main_led_output_fault && flash_go)
                begin
                    next_mode  = fls_pkg::MODE_FLASH;
                    next_state = fls_pkg::ST_SOFTSTART;
                    next_src   = allow;
                end
                else if (!ind_fault && ind_go)
                begin
                    next_mode  = fls_pkg::MODE_IND;
                    next_state = fls_pkg::ST_IND;
                    next_src   = allow;
                end
                else
                    next_mode  = fls_pkg::MODE_NONE;
            // [R10] boost soft-start first
            fls_pkg::ST_SOFTSTART:
                if (stop)
                    next_state = fls_pkg::ST_IDLE;
                else if (boost_ok)
                begin
                    next_state = fls_pkg::ST_RAMP_UP;
                    next_cur   = fls_pkg::FLASH_START_MA;
                end
            // [R4] ramp up to full scale
            fls_pkg::ST_RAMP_UP:
                if (stop)
                    next_state = fls_pkg::ST_RAMP_OFF;
                else if (cur == fls_pkg::FULL_SCALE_MA)
                    next_state = fls_pkg::ST_CHECK;
                else if (step)
                    next_cur   = cur + lsb;
            // [R11] check passed, go on
            fls_pkg::ST_CHECK:
                next_state = is_flash ? fls_pkg::ST_SETTLE : fls_pkg::ST_HOLD;
            // [R8] hold before ramp down
            fls_pkg::ST_HOLD:
                if (stop)
                    next_state = fls_pkg::ST_RAMP_OFF;
                else if (hold_cnt == 12'(fls_pkg::HOLD_CYC - 1))
                    next_state = fls_pkg::ST_SETTLE;
            // [R16] ramp on level change
            fls_pkg::ST_SETTLE:
                if (stop)
                    next_state = fls_pkg::ST_RAMP_OFF;
                else if (step && cur < target)
                    next_cur   = cur + lsb;
                else if (step && cur > target)
                    next_cur   = cur - lsb;
            // [R14] ramp down on disable
            fls_pkg::ST_RAMP_OFF:
                if (step && cur <= start)
                begin
                    next_cur   = 11'h000;
                    next_state = fls_pkg::ST_IDLE;
                end
                else if (step)
                    next_cur   = cur - lsb;
            fls_pkg::ST_IND:
                if (ind_flt)
                begin
                    ind_ev     = 1'b1;
                    next_state = fls_pkg::ST_IDLE;
                end
                else if (stop)
                    next_state = fls_pkg::ST_IDLE;
        endcase
        // [R20] expiry ends flash; fault only in maximum-duration style
        if (expire && state != fls_pkg::ST_RAMP_OFF)
        begin
            clr_on     = !src_pin;
            tmr_ev     = max_style;
            next_state = max_style ? fls_pkg::ST_IDLE : fls_pkg::ST_RAMP_OFF;
            next_cur   = max_style ? 11'h000 : cur;
        end
        // [R5] fault cuts current without ramp
        if (mon && main_led_output_flt)
        begin
            main_led_output_ev    = 1'b1;
            clr_on     = 1'b1;
            next_state = fls_pkg::ST_IDLE;
            next_cur   = 11'h000;
        end
    end

    // State and output flops; outputs follow the next values so they come from flops.
    always_ff @(posedge I_MCLK)
    begin
        state      <= I_SYS_RST ? fls_pkg::ST_IDLE : next_state;
        mode       <= I_SYS_RST ? fls_pkg::MODE_NONE : next_mode;
        cur        <= I_SYS_RST ? 11'h000 : next_cur;
        src_pin    <= ~I_SYS_RST & next_src;
        O_LED_MA   <= I_SYS_RST ? 11'h000 : next_cur;
        O_MAIN_LED_OUTPUT_ON  <= ~I_SYS_RST & (next_cur != 11'h000);
        O_BOOST_ON <= ~I_SYS_RST & next_mode == fls_pkg::MODE_FLASH & next_state != fls_pkg::ST_IDLE;
        O_IND_ON   <= ~I_SYS_RST & next_state == fls_pkg::ST_IND;
    end

    // Checks of the sequencing.
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);

    a_debounce_len: assert property ($changed(db_level) |-> $past(db_cnt) == 12'(fls_pkg::DEBOUNCE_CYC - 1)) // [R3]
        else $error("torch level changed before debounce time");
    a_shutdown_torch: assert property ((busy && !chip_en && $past(!chip_en, 2)) |-> ##1 // [R1]
        (!busy || mode == fls_pkg::MODE_TORCH || state == fls_pkg::ST_RAMP_OFF))
        else $error("non-torch mode active in shutdown");
    a_ramp_start: assert property ($rose(O_MAIN_LED_OUTPUT_ON) |-> O_LED_MA == start) // [R15]
        else $error("ramp did not start at first step");
    a_ramp_step: assert property ((state == fls_pkg::ST_RAMP_UP && $past(state) == fls_pkg::ST_RAMP_UP // [R14]
        && $changed(cur)) |-> cur == $past(cur) + lsb)
        else $error("ramp step size wrong");
    a_check_full: assert property (state == fls_pkg::ST_CHECK |-> cur == fls_pkg::FULL_SCALE_MA) // [R11]
        else $error("check not at full scale");
    a_fault_cut: assert property (main_led_output_ev |=> cur == 11'h000 && state == fls_pkg::ST_IDLE && main_led_output_fault) // [R5]
        else $error("fault did not cut current");
    a_soft_first: assert property ((is_flash && $rose(cur != 11'h000)) |-> $past(boost_ok)) // [R10]
        else $error("flash ramp before soft-start");
    a_one_mode: assert property ((busy && $past(busy)) |-> mode == $past(mode)) // [R21]
        else $error("mode changed while active");
    a_timer_fault: assert property (tmr_ev |-> max_style && is_flash ##1 tmr_fault && !O_MAIN_LED_OUTPUT_ON) // [R19]
        else $error("timer fault outside maximum style");

    c_torch_full: cover property (mode == fls_pkg::MODE_TORCH && state == fls_pkg::ST_HOLD);
    c_flash_expire: cover property (expire && !max_style);
    c_led_fault: cover property (main_led_output_ev);
    c_ind_on: cover property (O_IND_ON);
endmodule : fls_sequencer

/* shared/fls_pkg.sv */
// Constants, register layout and types for the LED mode sequencer.
// Assumes a 10 MHz system clock; all counts derive from that rate.
package fls_pkg;
    // Clock rate and timing figures.
    localparam int CLK_MHZ        = 10;
    localparam int RAMP_STEP_US   = 32;
    localparam int RAMP_STEP_CYC  = RAMP_STEP_US * CLK_MHZ;
    localparam int DEBOUNCE_US    = 256;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
    localparam int HOLD_US        = 400;
    localparam int HOLD_CYC       = HOLD_US * CLK_MHZ;
    localparam int TIMER_TICK_NS  = 1024000;
    localparam int TIMER_TICK_CYC = TIMER_TICK_NS / (1000 / CLK_MHZ);

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LEVEL  = 8'h04;
    localparam logic [7:0] ADDR_TIMER  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // Field positions of the level and status registers.
    localparam int LVL_TORCH_LSB = 0;
    localparam int LVL_FLASH_LSB = 4;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_CUR_LSB  = 16;

    // Reset values.
    localparam logic [6:0] CTRL_RST  = 7'h00;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [7:0] TIMER_RST = 8'h00;

    // Function select codes.
    localparam logic [1:0] FN_TORCH  = 2'h0;
    localparam logic [1:0] FN_IND    = 2'h1;
    localparam logic [1:0] FN_ASSIST = 2'h2;
    localparam logic [1:0] FN_FLASH  = 2'h3;

    // Current figures in mA.
    localparam logic [10:0] TORCH_START_MA = 11'h01E;
    localparam logic [10:0] TORCH_LSB_MA   = 11'h00A;
    localparam logic [10:0] FLASH_START_MA = 11'h032;
    localparam logic [10:0] FLASH_LSB_MA   = 11'h032;
    localparam logic [10:0] FULL_SCALE_MA  = 11'h064;
    localparam logic [10:0] FLASH_BASE_MA  = 11'h064;

    // Control register; a packed struct lists its top bit first, so bit 6 comes first here.
    typedef struct packed {
        logic       duration_style;
        logic       torch_allow;
        logic       strobe_input_allow;
        logic       indicator_select;
        logic [1:0] led_output_function_sel;
        logic       led_output_on_bit;
    } fls_ctrl_s;

    typedef enum logic [2:0] {ST_IDLE, ST_SOFTSTART, ST_RAMP_UP, ST_CHECK,
                              ST_HOLD, ST_SETTLE, ST_RAMP_OFF, ST_IND} fls_state_e;
    typedef enum logic [2:0] {MODE_NONE, MODE_TORCH, MODE_ASSIST, MODE_FLASH, MODE_IND} fls_mode_e;
endpackage : fls_pkg

/* verification/fls_regulator_model.sv */
// Behavioural model of the regulator and boost stage that follow the sequencer.
// Assumes the bench commands LED faults through i_fault_cmd; otherwise the LED is healthy.
`timescale 1ns/1ps
module fls_regulator_model (
    input  wire logic        i_clk,
    input  wire logic        i_boost_on,
    input  wire logic [10:0] i_led_ma,
    input  wire logic        i_fault_cmd,
    output logic             o_boost_ready,
    output logic             o_main_led_output_fault
);
    int ss_cnt = 0;

    // Soft-start takes 50 cycles, so a sequencer that ramps early is caught.
    always_ff @(posedge i_clk)
    begin
        ss_cnt <= i_boost_on ? ss_cnt + 1 : 0;
    end
    assign o_boost_ready = (ss_cnt >= 50);

    // An open or short only shows once current flows at full scale.
    assign o_main_led_output_fault = i_fault_cmd && (i_led_ma >= 11'h064);
endmodule : fls_regulator_model

/* verification/fls_sequencer_tb.sv */
// Self-checking bench for the LED mode sequencer, driven over APB and the pins.
// Assumes TICK_CYC of 20 so flash timers stay short.
`timescale 1ns/1ps
module fls_sequencer_tb;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, torch = 0, stb = 0, cen = 1, fcmd = 0, ifault = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, main_led_output_on, boost_on, ind_on, bready, ffault, err;
    logic [10:0] led;
    int          err_count = 0, checks = 0, n;

    always #50 clk = ~clk;

    fls_sequencer #(.TICK_CYC(20)) fls_sequencer_inst (.I_MCLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_TORCH_EN(torch),
        .I_STROBE(stb), .I_CHIP_EN(cen), .I_MAIN_LED_OUTPUT_FAULT(ffault), .I_IND_FAULT(ifault),
        .I_BOOST_READY(bready), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_LED_MA(led), .O_MAIN_LED_OUTPUT_ON(main_led_output_on), .O_BOOST_ON(boost_on), .O_IND_ON(ind_on));
    fls_regulator_model fls_regulator_model_inst (.i_clk(clk), .i_boost_on(boost_on), .i_led_ma(led),
        .i_fault_cmd(fcmd), .o_boost_ready(bready), .o_main_led_output_fault(ffault));

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 20) chk("pready", 0, 1);
    endtask : apb

    // Waits for a current level, bounded; n returns the cycles it took.
    task wait_led(input logic [10:0] v, input int lim);
        n = 0;
        while (led !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk("led_ma", 32'(led), 32'(v));
    endtask : wait_led

    task print_verdict;
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Watchdog: the whole sequence needs roughly 30k cycles, so twice that means a hang.
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        apb(0, 8'h00, 0);
        chk("ctrl_rst", rd, 0);
        apb(0, 8'h04, 0);
        chk("level_rst", rd, 0);
        apb(0, 8'h08, 0);
        chk("timer_rst", rd, 0);
        apb(1, 8'h0C, 32'hFF);
        apb(0, 8'h0C, 0);
        chk("status_ro", rd, 0);
        apb(0, 8'h10, 0);
        chk("unmapped_err", err, 1);
        chk("unmapped_rd", rd, 0);
        // Serial torch, final level code 3 is 60 mA.
        apb(1, 8'h04, 32'h13);
        apb(1, 8'h00, 32'h01);
        wait_led(11'h01E, 20);
        wait_led(11'h028, 340);
        chk("step_gap", n >= 300, 1);
        wait_led(11'h064, 2000);
        apb(0, 8'h0C, 0);
        chk("mode_torch", rd[6:4], 1);
        wait_led(11'h05A, 4400);
        chk("hold_gap", n >= 3900, 1);
        wait_led(11'h03C, 1400);
        apb(1, 8'h00, 32'h00);
        wait_led(11'h032, 340);
        wait_led(11'h000, 1400);
        chk("main_led_output_off", main_led_output_on, 0);
        // Register flash to 200 mA; timer of 256 ticks ends it one-shot.
        apb(1, 8'h08, 32'hFF);
        apb(1, 8'h00, 32'h07);
        repeat (5) @(posedge clk);
        chk("boost_on", boost_on, 1);
        chk("soft_start", 32'(led), 0);
        wait_led(11'h032, 200);
        chk("ss_wait", n >= 40, 1);
        wait_led(11'h064, 700);
        chk("flash_gap", n >= 600, 1);
        wait_led(11'h0C8, 1500);
        wait_led(11'h000, 8000);
        apb(0, 8'h0C, 0);
        chk("oneshot_nofault", rd[2], 0);
        // Strobe flash in maximum-duration style; a 16-tick timer expires while the strobe is held.
        apb(1, 8'h08, 32'h0F);
        apb(1, 8'h00, 32'h57);
        @(posedge clk);
        stb <= 1'b1;
        repeat (200) @(posedge clk);
        chk("maxdur_on", 32'(led), 32'h32);
        repeat (400) @(posedge clk);
        chk("maxdur_led", 32'(led), 0);
        apb(0, 8'h0C, 0);
        chk("maxdur_fault", rd[2], 1);
        stb <= 1'b0;
        apb(1, 8'h00, 32'h00);
        // Assist with an LED fault at full scale.
        fcmd <= 1'b1;
        apb(1, 8'h00, 32'h05);
        wait_led(11'h064, 2500);
        wait_led(11'h000, 10);
        apb(0, 8'h0C, 0);
        chk("fault_set", rd[0], 1);
        apb(0, 8'h0C, 0);
        chk("fault_clr", rd[0], 0);
        fcmd <= 1'b0;
        // Indicator by the on bit, then an indicator fault that drops it and latches status.
        apb(1, 8'h00, 32'h0B);
        repeat (10) @(posedge clk);
        chk("ind_on", ind_on, 1);
        apb(1, 8'h00, 32'h00);
        repeat (10) @(posedge clk);
        chk("ind_off", ind_on, 0);
        ifault <= 1'b1;
        apb(1, 8'h00, 32'h0B);
        repeat (10) @(posedge clk);
        chk("ind_fault_off", ind_on, 0);
        ifault <= 1'b0;
        apb(1, 8'h00, 32'h00);
        apb(0, 8'h0C, 0);
        chk("ind_fault", rd[1], 1);
        // Torch pin in shutdown: a short pulse is rejected, a long one is taken.
        cen <= 1'b0;
        apb(1, 8'h00, 32'h20);
        torch <= 1'b1;
        repeat (1000) @(posedge clk);
        chk("short_pulse", 32'(led), 0);
        torch <= 1'b0;
        repeat (3000) @(posedge clk);
        torch <= 1'b1;
        wait_led(11'h01E, 2700);
        chk("debounce", n >= 2500, 1);
        torch <= 1'b0;
        wait_led(11'h000, 12000);
        print_verdict();
    end
endmodule : fls_sequencer_tb
